// File: pkg/mtseq_pkg.sv
`default_nettype none
package mtseq_pkg;
  // ==========================================================
  // Widths and limits
  localparam int unsigned MTSEQ_DW = 24;
  localparam int unsigned MTSEQ_CW = 16;
  localparam logic [15:0] MTSEQ_CNT_MIN = 16'h0001;
  localparam logic [15:0] MTSEQ_CNT_MAX = 16'hC350;
  localparam int unsigned MTSEQ_STORE_DEPTH = 1024;
  localparam int unsigned MTSEQ_AW = 10;
  localparam logic [10:0] MTSEQ_STORE_FULL = 11'h400;
  localparam int unsigned MTSEQ_FIFO_DEPTH = 16;
  // ==========================================================
  // Timing
  localparam int unsigned MTSEQ_CLK_MHZ = 250;
  localparam int unsigned MTSEQ_SETUP_MS = 20;
  localparam int unsigned MTSEQ_SETUP_CYC = MTSEQ_SETUP_MS * 1000 * MTSEQ_CLK_MHZ;
  localparam int unsigned MTSEQ_US_CYC = MTSEQ_CLK_MHZ;
  localparam int unsigned MTSEQ_DELAY_MAX_S = 3600;
  localparam logic [31:0] MTSEQ_DELAY_MAX_US = 32'hD693A400;
  // ==========================================================
  // Trigger source codes
  localparam logic [1:0] MTSEQ_SRC_BUS = 2'h0;
  localparam logic [1:0] MTSEQ_SRC_IMM = 2'h1;
  localparam logic [1:0] MTSEQ_SRC_EXT = 2'h2;
  // Readback tokens, packed ASCII
  localparam logic [23:0] MTSEQ_TOK_BUS = 24'h425553;
  localparam logic [23:0] MTSEQ_TOK_IMM = 24'h494D4D;
  localparam logic [23:0] MTSEQ_TOK_EXT = 24'h455854;
  localparam logic [31:0] MTSEQ_INF_SENTINEL = 32'h7E6E2B2A;
  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {MTSEQ_IDLE, MTSEQ_SETUP, MTSEQ_WAIT, MTSEQ_DELAY, MTSEQ_SAMPLE} mtseq_state_e;
endpackage
`default_nettype wire

// File: design/mtseq_top.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Take programmed readings per accepted trigger
// - Source is bus, immediate or external
// - Ignore triggers outside wait-for-trigger
// - Trigger in wait state starts measuring
// - 20 ms setup, external pulses dropped
// - Configure_and_query_a, read or arm enter wait
// - Arm fills 1024-entry store until full
// - Read query sends readings to output
// - Delay 0 to 3600 s before samples
// - Auto delay derived; explicit write disables
// - Accept programmed triggers, then idle
// - Infinite count runs until device clear
// - Infinite count reads back sentinel value
// - Local mode ignores trigger count
// - Local mode always ready unless measuring
// - Source readback gives three tokens
// - Fetch moves stored readings to output
// - Store disabled: no store, fetch errors

// ==========================================================
// Output FIFO
module mtseq_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Sync reset
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  input wire logic in_valid_i, // Write valid
  output logic in_ready_o, // Not full
  output logic [WIDTH-1:0] out_data_o, // Read data
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i // Read accept
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;
  // Pointer and count update
  always_comb begin
    push = in_valid_i && (cnt_q != (PW+1)'(DEPTH));
    pop = out_ready_i && (cnt_q != '0);
    wp_d = push ? wp_q + PW'(1) : wp_q;
    rp_d = pop ? rp_q + PW'(1) : rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  // Storage entries
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (push && wp_q == PW'(g)) begin
        mem_q[g] <= in_data_i;
      end
    end
  end
  assign in_ready_o = cnt_q != (PW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
endmodule // mtseq_fifo

// ==========================================================
// Trigger sequencer
module mtseq_top #(
  parameter int unsigned SETUP_CYC = mtseq_pkg::MTSEQ_SETUP_CYC,
  parameter int unsigned US_CYC = mtseq_pkg::MTSEQ_US_CYC
) (
  input wire logic clk_i, // 250 MHz clock
  input wire logic nrst_i, // Sync reset, low
  input wire logic arm_to_memory_cmd_i, // Arm, readings to store
  input wire logic read_query_cmd_i, // Arm, readings to output
  input wire logic configure_and_query_a_i, // Configure_and_query_a query, also enables store
  input wire logic fetch_cmd_i, // Move store to output
  input wire logic bus_trig_i, // Bus trigger pulse
  input wire logic device_clear_i, // Return to idle
  input wire logic ext_trig_i, // External trigger pin
  input wire logic local_mode_i, // Front-panel control
  input wire logic [1:0] src_sel_i, // Trigger source
  input wire logic src_wr_i, // Source write strobe
  input wire logic [15:0] sample_cnt_i, // Readings per trigger
  input wire logic [15:0] trig_cnt_i, // Triggers per arm
  input wire logic trig_inf_i, // Infinite trigger count
  input wire logic [31:0] delay_us_i, // Explicit delay, us
  input wire logic delay_wr_i, // Explicit delay write
  input wire logic auto_delay_on_i, // Auto delay enable write
  input wire logic [31:0] auto_delay_us_i, // Derived auto delay, us
  input wire logic store_en_wr_i, // Store enable write
  input wire logic store_en_i, // Store enable value
  input wire logic [23:0] adc_data_i, // Reading value
  input wire logic adc_valid_i, // Reading done pulse
  output logic adc_start_o, // Start one reading
  output logic [23:0] out_data_o, // Output buffer data
  output logic out_valid_o, // Output buffer valid
  input wire logic out_ready_i, // Output buffer accept
  output logic [1:0] state_o, // 0 idle,1 wait,2 busy
  output logic [23:0] src_token_o, // Source token
  output logic [31:0] trig_cnt_rb_o, // Trigger count readback
  output logic auto_delay_o, // Auto delay flag
  output logic [10:0] store_points_o, // Readings in store
  output logic fetch_err_o // Fetch refused pulse
);
  mtseq_pkg::mtseq_state_e st_q, st_d;
  logic [1:0] src_q, src_d;
  logic auto_q, auto_d, store_en_q, store_en_d, to_mem_q, to_mem_d;
  logic [31:0] dly_q, dly_d, us_q, us_d;
  logic [31:0] cyc_q, cyc_d;
  logic [15:0] smp_q, smp_d, trg_q, trg_d;
  logic start_q, start_d, busy_q, busy_d, ferr_q, ferr_d, drain_q, drain_d;
  logic [23:0] store_q [mtseq_pkg::MTSEQ_STORE_DEPTH];
  logic [10:0] pts_q, pts_d, rd_q, rd_d;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic ext_ev, trig_ev, arm, fin_trig;
  logic [23:0] f_data;
  logic f_valid, f_ready, st_wr;
  logic [1:0] st_code_q;
  logic [23:0] tok_q;
  logic [31:0] rb_q;

  // External trigger sync and edge detect
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_trig_i;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  assign ext_ev = ext_s2_q && !ext_s3_q;

  // Trigger selection and arming
  always_comb begin
    case (src_q)
      mtseq_pkg::MTSEQ_SRC_BUS: trig_ev = bus_trig_i;
      mtseq_pkg::MTSEQ_SRC_EXT: trig_ev = ext_ev;
      default: trig_ev = 1'b1;
    endcase
    arm = arm_to_memory_cmd_i || read_query_cmd_i || configure_and_query_a_i;
    // Local mode ignores count; remote checks count or infinite
    fin_trig = !local_mode_i && !trig_inf_i && (trg_q + 16'h0001 >= trig_cnt_i);
  end

  // Configuration and sequencer next state
  always_comb begin
    src_d = src_wr_i ? src_sel_i : src_q;
    auto_d = auto_q;
    dly_d = dly_q;
    if (delay_wr_i) begin
      auto_d = 1'b0;
      dly_d = (delay_us_i > mtseq_pkg::MTSEQ_DELAY_MAX_US) ? mtseq_pkg::MTSEQ_DELAY_MAX_US : delay_us_i;
    end else if (auto_delay_on_i) begin
      auto_d = 1'b1;
    end
    store_en_d = store_en_wr_i ? store_en_i : (configure_and_query_a_i ? 1'b1 : store_en_q);
    st_d = st_q;
    to_mem_d = to_mem_q;
    cyc_d = cyc_q;
    us_d = us_q;
    smp_d = smp_q;
    trg_d = trg_q;
    start_d = 1'b0;
    busy_d = busy_q;
    case (st_q)
      mtseq_pkg::MTSEQ_IDLE: begin
        if (local_mode_i) begin
          st_d = mtseq_pkg::MTSEQ_WAIT;
          to_mem_d = 1'b0;
          trg_d = '0;
        end else if (arm) begin
          st_d = mtseq_pkg::MTSEQ_SETUP;
          to_mem_d = arm_to_memory_cmd_i;
          cyc_d = '0;
          trg_d = '0;
        end
      end
      mtseq_pkg::MTSEQ_SETUP: begin
        // Setup ignores every trigger, external included
        cyc_d = cyc_q + 32'h1;
        if (cyc_q + 32'h1 >= SETUP_CYC) begin
          st_d = mtseq_pkg::MTSEQ_WAIT;
        end
      end
      mtseq_pkg::MTSEQ_WAIT: begin
        if (trig_ev) begin
          st_d = mtseq_pkg::MTSEQ_DELAY;
          smp_d = '0;
          cyc_d = '0;
          us_d = '0;
        end
      end
      mtseq_pkg::MTSEQ_DELAY: begin
        // Microsecond tick counter for delay
        cyc_d = cyc_q + 32'h1;
        if (cyc_q + 32'h1 >= US_CYC) begin
          cyc_d = '0;
          us_d = us_q + 32'h1;
        end
        if (us_q >= (auto_q ? auto_delay_us_i : dly_q)) begin
          st_d = mtseq_pkg::MTSEQ_SAMPLE;
          start_d = 1'b1;
          busy_d = 1'b1;
        end
      end
      mtseq_pkg::MTSEQ_SAMPLE: begin
        if (adc_valid_i && busy_q) begin
          busy_d = 1'b0;
          smp_d = smp_q + 16'h0001;
          if (smp_q + 16'h0001 < sample_cnt_i) begin
            st_d = mtseq_pkg::MTSEQ_DELAY;
            cyc_d = '0;
            us_d = '0;
          end else if (fin_trig) begin
            st_d = mtseq_pkg::MTSEQ_IDLE;
          end else begin
            st_d = mtseq_pkg::MTSEQ_WAIT;
            trg_d = trg_q + 16'h0001;
          end
        end
      end
      default: st_d = mtseq_pkg::MTSEQ_IDLE;
    endcase
    if (device_clear_i) begin
      st_d = mtseq_pkg::MTSEQ_IDLE;
      busy_d = 1'b0;
      start_d = 1'b0;
    end
  end

  // Store and output path next values
  always_comb begin
    st_wr = adc_valid_i && busy_q && to_mem_q && store_en_q && (pts_q < mtseq_pkg::MTSEQ_STORE_FULL);
    pts_d = pts_q;
    rd_d = rd_q;
    drain_d = drain_q;
    ferr_d = 1'b0;
    f_valid = 1'b0;
    f_data = adc_data_i;
    if (arm && st_q == mtseq_pkg::MTSEQ_IDLE && arm_to_memory_cmd_i) begin
      pts_d = '0;
    end
    if (st_wr) begin
      pts_d = pts_q + 11'h001;
    end
    if (fetch_cmd_i) begin
      if (!store_en_q) begin
        ferr_d = 1'b1;
      end else begin
        drain_d = 1'b1;
        rd_d = '0;
      end
    end else if (drain_q) begin
      f_valid = rd_q < pts_q;
      f_data = store_q[rd_q[9:0]];
      if (!f_valid) begin
        drain_d = 1'b0;
      end else if (f_ready) begin
        rd_d = rd_q + 11'h001;
      end
    end else begin
      f_valid = adc_valid_i && busy_q && !to_mem_q;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_q <= mtseq_pkg::MTSEQ_IDLE;
      src_q <= mtseq_pkg::MTSEQ_SRC_IMM;
      auto_q <= 1'b1;
      dly_q <= '0;
      store_en_q <= 1'b1;
      to_mem_q <= 1'b0;
      cyc_q <= '0;
      us_q <= '0;
      smp_q <= '0;
      trg_q <= '0;
      start_q <= 1'b0;
      busy_q <= 1'b0;
      pts_q <= '0;
      rd_q <= '0;
      drain_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      src_q <= src_d;
      auto_q <= auto_d;
      dly_q <= dly_d;
      store_en_q <= store_en_d;
      to_mem_q <= to_mem_d;
      cyc_q <= cyc_d;
      us_q <= us_d;
      smp_q <= smp_d;
      trg_q <= trg_d;
      start_q <= start_d;
      busy_q <= busy_d;
      pts_q <= pts_d;
      rd_q <= rd_d;
      drain_q <= drain_d;
      ferr_q <= ferr_d;
    end
  end

  // Reading store entries
  for (genvar g = 0; g < mtseq_pkg::MTSEQ_STORE_DEPTH; g++) begin : g_store
    always_ff @(posedge clk_i) begin
      if (st_wr && pts_q[9:0] == 10'(g)) begin
        store_q[g] <= adc_data_i;
      end
    end
  end

  // Status readback registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_code_q <= 2'h0;
      tok_q <= mtseq_pkg::MTSEQ_TOK_IMM;
      rb_q <= 32'h1;
    end else begin
      // Codes follow the next state so the status matches the sequencer
      st_code_q <= (st_d == mtseq_pkg::MTSEQ_IDLE) ? 2'h0 : (st_d == mtseq_pkg::MTSEQ_WAIT) ? 2'h1 : 2'h2;
      case (src_d)
        mtseq_pkg::MTSEQ_SRC_BUS: tok_q <= mtseq_pkg::MTSEQ_TOK_BUS;
        mtseq_pkg::MTSEQ_SRC_EXT: tok_q <= mtseq_pkg::MTSEQ_TOK_EXT;
        default: tok_q <= mtseq_pkg::MTSEQ_TOK_IMM;
      endcase
      rb_q <= trig_inf_i ? mtseq_pkg::MTSEQ_INF_SENTINEL : {16'h0000, trig_cnt_i};
    end
  end

  mtseq_fifo #(.WIDTH(mtseq_pkg::MTSEQ_DW), .DEPTH(mtseq_pkg::MTSEQ_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_data_i(f_data),
    .in_valid_i(f_valid),
    .in_ready_o(f_ready),
    .out_data_o(out_data_o),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i)
  );

  assign adc_start_o = start_q;
  assign state_o = st_code_q;
  assign src_token_o = tok_q;
  assign trig_cnt_rb_o = rb_q;
  assign auto_delay_o = auto_q;
  assign store_points_o = pts_q;
  assign fetch_err_o = ferr_q;
endmodule // mtseq_top
`default_nettype wire

// File: tb/mtseq_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Reading converter model
module mtseq_adc_model (
  input wire logic clk_i, // Clock
  input wire logic start_i, // Start one reading
  output logic [23:0] data_o, // Reading value
  output logic valid_o // Reading done pulse
);
  int lat;
  // Answer each start after 1 to 4 cycles, data scrambled when idle
  initial begin
    valid_o = 1'b0;
    data_o = 24'h000000;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        lat = $urandom_range(4, 1);
        repeat (lat) @(posedge clk_i);
        data_o <= 24'($urandom);
        valid_o <= 1'b1;
        @(posedge clk_i);
        valid_o <= 1'b0;
        data_o <= ~data_o;
      end
    end
  end
endmodule // mtseq_adc_model
`default_nettype wire

// File: tb/mtseq_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Sequencer port checks
module mtseq_chk #(
  parameter int unsigned SETUP_CYC = 20, // Setup cycles
  parameter int unsigned US_CYC = 2 // Cycles per us
) (
  input wire logic clk_i, // Clock
  input wire logic nrst_i, // Reset
  input wire logic arm_to_memory_cmd_i, // Arm to store
  input wire logic read_query_cmd_i, // Arm direct
  input wire logic configure_and_query_a_i, // Configure_and_query_a query
  input wire logic fetch_cmd_i, // Fetch
  input wire logic device_clear_i, // Clear
  input wire logic local_mode_i, // Local
  input wire logic [1:0] src_sel_i, // Source
  input wire logic src_wr_i, // Source write
  input wire logic [15:0] trig_cnt_i, // Triggers
  input wire logic trig_inf_i, // Infinite
  input wire logic delay_wr_i, // Delay write
  input wire logic auto_delay_on_i, // Auto on
  input wire logic adc_start_o, // Start
  input wire logic [23:0] out_data_o, // Out data
  input wire logic out_valid_o, // Out valid
  input wire logic out_ready_i, // Out accept
  input wire logic [1:0] state_o, // State
  input wire logic [23:0] src_token_o, // Token
  input wire logic [31:0] trig_cnt_rb_o, // Readback
  input wire logic auto_delay_o, // Auto flag
  input wire logic [10:0] store_points_o, // Stored
  input wire logic fetch_err_o // Fetch error
);
  logic arm_any;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Any arming command
  assign arm_any = arm_to_memory_cmd_i | read_query_cmd_i | configure_and_query_a_i;
  // ==========================================================
  // Properties
  AST_IDLE:
    assert property (state_o == 2'h0 && !arm_any && !local_mode_i |=> state_o == 2'h0) else $error("left idle");
  AST_ARM:
    assert property (state_o == 2'h0 && arm_any && !local_mode_i && !device_clear_i
      |=> (state_o == 2'h2)[*8] ##[1:30] state_o == 2'h1) else $error("arm setup wrong");
  AST_START:
    assert property (adc_start_o |-> state_o == 2'h2) else $error("start outside busy");
  AST_TOK:
    assert property (src_wr_i && src_sel_i == mtseq_pkg::MTSEQ_SRC_EXT
      |=> src_token_o == mtseq_pkg::MTSEQ_TOK_EXT) else $error("token wrong");
  AST_RB:
    assert property ($past(nrst_i) |-> trig_cnt_rb_o == ($past(trig_inf_i) ? mtseq_pkg::MTSEQ_INF_SENTINEL
      : {16'h0000, $past(trig_cnt_i)})) else $error("count readback wrong");
  AST_AUTO:
    assert property (delay_wr_i && !auto_delay_on_i |=> !auto_delay_o) else $error("auto not cleared");
  AST_AUTO_SET:
    assert property ($past(nrst_i) && $rose(auto_delay_o) |-> $past(auto_delay_on_i)) else $error("auto set");
  AST_ERR:
    assert property (fetch_err_o |-> $past(fetch_cmd_i)) else $error("stray fetch error");
  AST_CLR:
    assert property (device_clear_i && !local_mode_i |=> state_o == 2'h0) else $error("clear ignored");
  AST_HOLD:
    assert property (out_valid_o && !out_ready_i && !device_clear_i
      |=> out_valid_o && $stable(out_data_o)) else $error("output word lost");
  AST_PTS:
    assert property (store_points_o <= 11'h400) else $error("store overfull");
endmodule // mtseq_chk
bind mtseq_top mtseq_chk #(.SETUP_CYC(SETUP_CYC), .US_CYC(US_CYC)) i_mtseq_chk (.clk_i, .nrst_i,
  .arm_to_memory_cmd_i, .read_query_cmd_i, .configure_and_query_a_i, .fetch_cmd_i, .device_clear_i,
  .local_mode_i, .src_sel_i, .src_wr_i, .trig_cnt_i, .trig_inf_i, .delay_wr_i, .auto_delay_on_i,
  .adc_start_o, .out_data_o, .out_valid_o, .out_ready_i, .state_o, .src_token_o, .trig_cnt_rb_o,
  .auto_delay_o, .store_points_o, .fetch_err_o);
`default_nettype wire

// File: tb/mtseq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench top
module mtseq_tb_top;
  logic clk_i, nrst_i, arm_to_memory_cmd_i, read_query_cmd_i, configure_and_query_a_i, fetch_cmd_i;
  logic bus_trig_i, device_clear_i, ext_trig_i, local_mode_i, src_wr_i, trig_inf_i, delay_wr_i;
  logic auto_delay_on_i, store_en_wr_i, store_en_i, adc_valid_i, adc_start_o, out_valid_o, out_ready_i;
  logic auto_delay_o, fetch_err_o;
  logic [1:0] src_sel_i, state_o;
  logic [15:0] sample_cnt_i, trig_cnt_i;
  logic [31:0] delay_us_i, auto_delay_us_i, trig_cnt_rb_o;
  logic [23:0] adc_data_i, out_data_o, src_token_o;
  logic [10:0] store_points_o;
  logic [23:0] exp_q[$];
  logic [23:0] tok[3];
  int err_total, compares, n_start, t_dly;
  bit chk_on;
  // Design and converter model
  mtseq_top #(.SETUP_CYC(20), .US_CYC(2)) i_mtseq_top (.clk_i, .nrst_i, .arm_to_memory_cmd_i,
    .read_query_cmd_i, .configure_and_query_a_i, .fetch_cmd_i, .bus_trig_i, .device_clear_i, .ext_trig_i,
    .local_mode_i, .src_sel_i, .src_wr_i, .sample_cnt_i, .trig_cnt_i, .trig_inf_i, .delay_us_i, .delay_wr_i,
    .auto_delay_on_i, .auto_delay_us_i, .store_en_wr_i, .store_en_i, .adc_data_i, .adc_valid_i, .adc_start_o,
    .out_data_o, .out_valid_o, .out_ready_i, .state_o, .src_token_o, .trig_cnt_rb_o, .auto_delay_o,
    .store_points_o, .fetch_err_o);
  mtseq_adc_model i_mtseq_adc_model (.clk_i(clk_i), .start_i(adc_start_o), .data_o(adc_data_i),
    .valid_o(adc_valid_i));
  // ==========================================================
  // Helpers
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i) s = 1'b1;
    @(negedge clk_i) s = 1'b0;
  endtask
  task automatic wait_st(logic [1:0] v);
    int n;
    n = 0;
    while (state_o !== v && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("state", 32'(v), 32'(state_o));
  endtask
  task automatic drain();
    int n;
    n = 0;
    out_ready_i = 1'b1;
    while (exp_q.size() > 0 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    chk("words_left", 0, 32'(exp_q.size()));
  endtask
  task complete_run;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Reference queue of readings and start counter
  always @(posedge clk_i) begin
    if (adc_start_o === 1'b1) n_start++;
    if (chk_on && adc_valid_i) exp_q.push_back(adc_data_i);
    if (chk_on && out_valid_o === 1'b1 && out_ready_i) begin
      if (exp_q.size() == 0) chk("extra_word", 0, 1);
      else chk("out_data", 32'(exp_q.pop_front()), 32'(out_data_o));
    end
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h57C9));
    {nrst_i, arm_to_memory_cmd_i, read_query_cmd_i, configure_and_query_a_i, fetch_cmd_i} = 5'h00;
    {bus_trig_i, device_clear_i, ext_trig_i, local_mode_i, src_wr_i, trig_inf_i, delay_wr_i} = 7'h00;
    {auto_delay_on_i, store_en_wr_i, store_en_i, out_ready_i} = 4'h1;
    {src_sel_i, sample_cnt_i, trig_cnt_i, delay_us_i} = {2'h1, 16'h0001, 16'h0001, 32'h00000001};
    auto_delay_us_i = 32'($urandom_range(2, 0));
    tok = '{mtseq_pkg::MTSEQ_TOK_BUS, mtseq_pkg::MTSEQ_TOK_IMM, mtseq_pkg::MTSEQ_TOK_EXT};
    chk_on = 1'b1;
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    chk("rst_tok", 32'(tok[1]), 32'(src_token_o));
    chk("rst_cnt", 1, trig_cnt_rb_o);
    chk("rst_auto", 1, 32'(auto_delay_o));
    for (int i = 0; i < 3; i++) begin
      src_sel_i = 2'(i);
      pulse(src_wr_i);
      chk("token", 32'(tok[i]), 32'(src_token_o));
      chk("no_arm", 0, 32'(state_o));
    end
    trig_inf_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("inf_rb", mtseq_pkg::MTSEQ_INF_SENTINEL, trig_cnt_rb_o);
    trig_inf_i = 1'b0;
    trig_cnt_i = 16'($urandom_range(50000, 1));
    repeat (2) @(negedge clk_i);
    chk("cnt_rb", {16'h0000, trig_cnt_i}, trig_cnt_rb_o);
    pulse(delay_wr_i);
    chk("auto_off", 0, 32'(auto_delay_o));
    pulse(auto_delay_on_i);
    chk("auto_on", 1, 32'(auto_delay_o));
    // Stored run, 10 readings x 2 triggers, fetched through a stalled buffer
    {src_sel_i, sample_cnt_i, trig_cnt_i, out_ready_i} = {2'h1, 16'h000A, 16'h0002, 1'b0};
    pulse(src_wr_i);
    pulse(arm_to_memory_cmd_i);
    wait_st(2'h0);
    chk("points", 20, 32'(store_points_o));
    chk("not_direct", 0, 32'(out_valid_o));
    pulse(fetch_cmd_i);
    repeat (30) @(negedge clk_i);
    chk("full_valid", 1, 32'(out_valid_o));
    drain();
    // Bus trigger, early one ignored
    {src_sel_i, sample_cnt_i, trig_cnt_i} = {2'h0, 16'h0002, 16'h0001};
    pulse(src_wr_i);
    pulse(bus_trig_i);
    n_start = 0;
    pulse(read_query_cmd_i);
    wait_st(2'h1);
    repeat (5) @(negedge clk_i);
    chk("bus_wait", 0, n_start);
    pulse(bus_trig_i);
    wait_st(2'h0);
    drain();
    chk("bus_reads", 2, n_start);
    // External pulse during setup dropped
    {src_sel_i, sample_cnt_i} = {2'h2, 16'h0001};
    pulse(src_wr_i);
    n_start = 0;
    pulse(read_query_cmd_i);
    pulse(ext_trig_i);
    wait_st(2'h1);
    repeat (5) @(negedge clk_i);
    chk("ext_setup", 0, n_start);
    pulse(ext_trig_i);
    wait_st(2'h0);
    drain();
    chk("ext_reads", 1, n_start);
    // Explicit 3 us delay holds back each start
    {src_sel_i, delay_us_i} = {2'h1, 32'h00000003};
    pulse(src_wr_i);
    pulse(delay_wr_i);
    pulse(read_query_cmd_i);
    wait_st(2'h1);
    t_dly = 0;
    while (adc_start_o !== 1'b1 && t_dly < 100) begin
      @(negedge clk_i);
      t_dly++;
    end
    chk("dly_cyc", 1, 32'(t_dly >= 6 && t_dly <= 9));
    wait_st(2'h0);
    drain();
    // Store off, fetch refused, configure_and_query_a query re-enables
    chk_on = 1'b0;
    {src_sel_i, store_en_i} = {2'h1, 1'b0};
    pulse(src_wr_i);
    pulse(store_en_wr_i);
    pulse(arm_to_memory_cmd_i);
    wait_st(2'h0);
    chk("off_points", 0, 32'(store_points_o));
    pulse(fetch_cmd_i);
    chk("fetch_err", 1, 32'(fetch_err_o));
    repeat (20) @(negedge clk_i);
    exp_q.delete();
    chk_on = 1'b1;
    pulse(configure_and_query_a_i);
    wait_st(2'h0);
    drain();
    pulse(fetch_cmd_i);
    chk("fetch_ok", 0, 32'(fetch_err_o));
    // Infinite count, then device clear
    chk_on = 1'b0;
    n_start = 0;
    trig_inf_i = 1'b1;
    pulse(read_query_cmd_i);
    repeat (200) @(negedge clk_i);
    chk("inf_runs", 1, 32'(n_start > 2));
    pulse(device_clear_i);
    wait_st(2'h0);
    trig_inf_i = 1'b0;
    // Local mode keeps re-arming
    n_start = 0;
    local_mode_i = 1'b1;
    repeat (300) @(negedge clk_i);
    chk("local_runs", 1, 32'(n_start > 2));
    local_mode_i = 1'b0;
    pulse(device_clear_i);
    wait_st(2'h0);
    complete_run();
  end
endmodule // mtseq_tb_top
`default_nettype wire
